// file: i2cs_regs.vh
`ifndef I2CS_REGS_VH
`define I2CS_REGS_VH
// Fixed upper nibble of the slave address when address mode is low
`define I2CS_ADDR_HI_FIXED     4'h5
// Master code pattern: upper five bits of 00001xxx
`define I2CS_MCODE_HI          5'h01
// Register index width
`define I2CS_RIDX_W            6
// Spike filter lengths in ns, rounded up to system clocks (F/S and HS settings)
`define I2CS_FLT_FS_NS         40
`define I2CS_FLT_HS_NS         20
`define I2CS_CLK_NS            20
`define I2CS_FLT_FS_CYC        ((`I2CS_FLT_FS_NS + `I2CS_CLK_NS - 1) / `I2CS_CLK_NS)
`define I2CS_FLT_HS_CYC        ((`I2CS_FLT_HS_NS + `I2CS_CLK_NS - 1) / `I2CS_CLK_NS)
// Data FIFO geometry
`define I2CS_FIFO_W            14
`define I2CS_FIFO_D            16
`define I2CS_FIFO_AW           4
`endif

// file: i2cs_fifo.v
`timescale 1ns/10ps
// Write FIFO between the serial port and the register side
module i2cs_fifo #(
  parameter W  = 14,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          clock,
  input  wire          nrst,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg [W-1:0]  mem_r [0:D-1];
  reg [AW:0]   wp_r;
  reg [AW:0]   rp_r;
  wire         full;
  wire         empty;

  // Extra pointer bit tells full from empty
  assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty     = (wp_r == rp_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rp_r[AW-1:0]];

  // Pointers and storage
  always @(posedge clock) begin
    if (!nrst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem_r[wp_r[AW-1:0]] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (out_ready && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// file: i2cs_filt.v
`timescale 1ns/10ps
`include "i2cs_regs.vh"
// Two-flop synchroniser followed by a spike filter of selectable length
module i2cs_filt (
  input  wire       clock,
  input  wire       nrst,
  input  wire       pin,
  input  wire       hs,
  output reg        level
);
  reg        s1_r;
  reg        s2_r;
  reg  [2:0] cnt_r;
  wire [2:0] lim;

  localparam integer LIM_FS = `I2CS_FLT_FS_CYC;
  localparam integer LIM_HS = `I2CS_FLT_HS_CYC;

  // Shorter window in high-speed mode; filter delay must fit a low phase
  assign lim = hs ? LIM_HS[2:0] : LIM_FS[2:0];

  // Level accepted only after it holds for lim cycles; lines idle high
  always @(posedge clock) begin
    if (!nrst) begin
      s1_r  <= 1'b1;
      s2_r  <= 1'b1;
      cnt_r <= 3'h0;
      level <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      if (s2_r == level)
        cnt_r <= 3'h0;
      else if (cnt_r + 3'h1 >= lim) begin
        level <= s2_r;
        cnt_r <= 3'h0;
      end else
        cnt_r <= cnt_r + 3'h1;
    end
  end
endmodule

// file: i2cs_port.v
`timescale 1ns/10ps
`include "i2cs_regs.vh"
// Behaviour
// - Slave only; never drives the clock
// - Receive and transmit at S, F, HS rates
// - Data line driven low or released only
// - Spike filters on both lines when selected
// - Sample data on clock rise, change when low
// - Detect START and STOP on the bus
// - Repeated START restarts address reception
// - MSB first, ack after every byte
// - Receiver holds ack low; transmitter releases
// - Master nack ends read; release the line
// - First byte is address; respond on match
// - Mode low: address 0101 plus three pins
// - Mode high: six pins, bit six zero
// - Straps sampled once after reset release
// - Write frame: address, index, then data, same register
// - Read returns the selected register repeatedly
// - Master code detected and not acknowledged
// - HS held across repeats; STOP returns F/S
// - Fast mode setting after reset
// - HS switches filters and slope control
// - Force bit keeps HS permanently
// - Without master code stay in F/S
// - Two-wire select pin enables this port
module i2cs_port (
  input  wire        clock,
  input  wire        nrst,
  input  wire        two_wire_sel,
  input  wire        address_mode_pin,
  input  wire [5:0]  adr_pin,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        force_high_speed_bit,
  output reg         hs_mode,
  output reg         hs_slope,
  output reg         busy,
  output reg         wr_valid,
  input  wire        wr_ready,
  output reg  [5:0]  wr_index,
  output reg  [7:0]  wr_data,
  output reg  [5:0]  rd_index,
  input  wire [7:0]  rd_data,
  output reg         rd_strobe,
  output reg  [6:0]  own_addr
);
  // Byte states, one-hot
  localparam ST_IDLE = 5'h01;
  localparam ST_ADDR = 5'h02;
  localparam ST_RIDX = 5'h04;
  localparam ST_WDAT = 5'h08;
  localparam ST_RDAT = 5'h10;

  reg  [4:0] state_r;
  reg  [2:0] bit_r;
  reg  [7:0] sh_r;
  reg        ack_ph_r;
  reg        ack_drv_r;
  reg        rd_ack_r;
  reg        scl_d_r;
  reg        sda_d_r;
  reg        hs_r;
  reg        mcode_r;
  reg        strap_done_r;
  reg  [1:0] mode_s_r;
  reg  [5:0] adr_s1_r;
  reg  [5:0] adr_s2_r;
  reg        mode_s2_r;
  reg        settle_r;
  reg        pend_r;
  wire       fifo_pop;
  reg        sel_s1_r;
  reg        sel_s2_r;
  reg  [5:0] ridx_r;
  wire       scl;
  wire       sda;
  wire       filt_hs;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_c;
  wire       stop_c;
  wire [7:0] byte_in;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [13:0] fifo_out_data;
  reg        fifo_in_valid;
  reg  [13:0] fifo_in_data;

  // True when the top seven bits name this device
  function addr_hit;
    input [7:0] b;
    input [6:0] own;
    begin
      addr_hit = (b[7:1] == own);
    end
  endfunction

  // Master code has the pattern 00001xxx
  function is_mcode;
    input [7:0] b;
    begin
      is_mcode = (b[7:3] == `I2CS_MCODE_HI);
    end
  endfunction

  assign filt_hs = hs_r | force_high_speed_bit;

  // Both lines filtered; HS picks the short window
  i2cs_filt u_fscl (
    .clock (clock),
    .nrst  (nrst),
    .pin   (scl_in),
    .hs    (filt_hs),
    .level (scl)
  );
  i2cs_filt u_fsda (
    .clock (clock),
    .nrst  (nrst),
    .pin   (sda_in),
    .hs    (filt_hs),
    .level (sda)
  );

  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  // Data edge while clock stays high
  assign start_c  = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_c   = scl & scl_d_r & ~sda_d_r & sda;
  assign byte_in  = {sh_r[6:0], sda};

  // Strap pins synchronised, caught once after reset release
  always @(posedge clock) begin
    if (!nrst) begin
      adr_s1_r     <= 6'h00;
      adr_s2_r     <= 6'h00;
      mode_s_r     <= 2'h0;
      sel_s1_r     <= 1'b0;
      sel_s2_r     <= 1'b0;
      strap_done_r <= 1'b0;
      mode_s2_r    <= 1'b0;
      settle_r     <= 1'b0;
      own_addr     <= 7'h00;
    end else begin
      adr_s1_r <= adr_pin;
      adr_s2_r <= adr_s1_r;
      mode_s_r <= {mode_s_r[0], address_mode_pin};
      sel_s1_r <= two_wire_sel;
      // Capture on the third edge, once both flops hold pin values
      if (!strap_done_r && settle_r) begin
        strap_done_r <= 1'b1;
        sel_s2_r     <= sel_s1_r;
        if (mode_s_r[1])
          own_addr <= {1'b0, adr_s2_r};
        else
          own_addr <= {`I2CS_ADDR_HI_FIXED, adr_s2_r[2:0]};
      end
      mode_s2_r <= 1'b1; // Lets the synchronisers fill first
      settle_r  <= mode_s2_r;
    end
  end

  // Writes queue in the FIFO so a slow register side cannot lose bytes
  i2cs_fifo #(
    .W  (`I2CS_FIFO_W),
    .D  (`I2CS_FIFO_D),
    .AW (`I2CS_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Pop only when the output stage is empty or being drained; popping
  // on ready alone would discard every other queued word
  assign fifo_pop = fifo_out_valid & (~wr_valid | wr_ready);

  // FIFO output registered toward the register side
  always @(posedge clock) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_index <= 6'h00;
      wr_data  <= 8'h00;
    end else if (fifo_pop) begin
      wr_valid <= 1'b1;
      wr_index <= fifo_out_data[13:8];
      wr_data  <= fifo_out_data[7:0];
    end else if (wr_ready) begin
      wr_valid <= 1'b0;
    end
  end

  // Protocol engine; acts only on bus clock edges and START/STOP from the master
  // A byte takes eight rises; pend_r marks the fall that opens the ninth
  // clock, ack_ph_r covers that ninth clock until its closing fall.
  always @(posedge clock) begin
    if (!nrst) begin
      state_r       <= ST_IDLE;
      bit_r         <= 3'h0;
      sh_r          <= 8'h00;
      pend_r        <= 1'b0;
      ack_ph_r      <= 1'b0;
      ack_drv_r     <= 1'b0;
      rd_ack_r      <= 1'b0;
      scl_d_r       <= 1'b1;
      sda_d_r       <= 1'b1;
      hs_r          <= 1'b0;
      mcode_r       <= 1'b0;
      ridx_r        <= 6'h00;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      hs_mode       <= 1'b0;
      hs_slope      <= 1'b0;
      busy          <= 1'b0;
      rd_index      <= 6'h00;
      rd_strobe     <= 1'b0;
      fifo_in_valid <= 1'b0;
      fifo_in_data  <= 14'h0000;
    end else begin
      scl_d_r       <= scl;
      sda_d_r       <= sda;
      rd_strobe     <= 1'b0;
      fifo_in_valid <= 1'b0;
      sda_out       <= 1'b0;
      hs_mode       <= hs_r | force_high_speed_bit;
      hs_slope      <= hs_r | force_high_speed_bit;
      rd_index      <= ridx_r;
      if (!sel_s2_r) begin
        // Port not selected: stay off the bus entirely
        state_r  <= ST_IDLE;
        sda_oe   <= 1'b0;
        busy     <= 1'b0;
        pend_r   <= 1'b0;
        ack_ph_r <= 1'b0;
      end else if (stop_c) begin
        state_r  <= ST_IDLE;
        busy     <= 1'b0;
        sda_oe   <= 1'b0;
        pend_r   <= 1'b0;
        ack_ph_r <= 1'b0;
        hs_r     <= 1'b0;
        mcode_r  <= 1'b0;
      end else if (start_c) begin
        state_r  <= ST_ADDR;
        busy     <= 1'b1;
        bit_r    <= 3'h0;
        pend_r   <= 1'b0;
        ack_ph_r <= 1'b0;
        sda_oe   <= 1'b0;
        if (mcode_r)
          hs_r <= 1'b1;
      end else if (scl_rise) begin
        if (ack_ph_r) begin
          // Master's answer to a byte we sent; low means more wanted
          rd_ack_r <= ~sda;
        end else if (!pend_r && (state_r == ST_ADDR ||
                     state_r == ST_RIDX || state_r == ST_WDAT)) begin
          sh_r  <= byte_in;
          bit_r <= bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            pend_r    <= 1'b1;
            ack_drv_r <= 1'b0;
            case (state_r)
              ST_ADDR: begin
                if (is_mcode(byte_in) && !hs_r)
                  mcode_r <= 1'b1;
                else if (addr_hit(byte_in, own_addr)) begin
                  ack_drv_r <= 1'b1;
                  if (byte_in[0]) begin
                    state_r   <= ST_RDAT;
                    rd_strobe <= 1'b1;
                  end else
                    state_r <= ST_RIDX;
                end else
                  state_r <= ST_IDLE;
              end
              ST_RIDX: begin
                ridx_r    <= byte_in[5:0];
                ack_drv_r <= 1'b1;
                state_r   <= ST_WDAT;
              end
              ST_WDAT: begin
                // Full FIFO answers nack rather than drop silently
                fifo_in_valid <= fifo_in_ready;
                fifo_in_data  <= {ridx_r, byte_in};
                ack_drv_r     <= fifo_in_ready;
              end
              default: state_r <= ST_IDLE;
            endcase
          end
        end
      end else if (scl_fall) begin
        if (pend_r) begin
          // Ninth clock opens: pull low for the whole pulse if acking
          pend_r   <= 1'b0;
          ack_ph_r <= 1'b1;
          sda_oe   <= ack_drv_r;
        end else if (ack_ph_r) begin
          // Ninth clock closes
          ack_ph_r <= 1'b0;
          if (state_r == ST_RDAT && rd_ack_r) begin
            sh_r   <= {rd_data[6:0], 1'b0};
            sda_oe <= ~rd_data[7];
            bit_r  <= 3'h1;
          end else if (state_r == ST_RDAT) begin
            sda_oe  <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            sda_oe <= 1'b0;
            bit_r  <= 3'h0;
          end
        end else if (state_r == ST_RDAT) begin
          if (bit_r == 3'h0) begin
            // Eight bits out: release for the master's answer
            sda_oe    <= 1'b0;
            ack_ph_r  <= 1'b1;
            rd_strobe <= 1'b1;
          end else begin
            sda_oe <= ~sh_r[7];
            sh_r   <= {sh_r[6:0], 1'b0};
            bit_r  <= bit_r + 3'h1;
          end
        end
      end
    end
  end
endmodule

// file: i2cs_port_sva.sv
`timescale 1ns/10ps
// Port checks on the two-wire slave
module i2cs_port_sva (
  input wire       clock,
  input wire       nrst,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       force_high_speed_bit,
  input wire       hs_mode,
  input wire       hs_slope,
  input wire       busy,
  input wire       wr_valid,
  input wire       wr_ready,
  input wire [5:0] wr_index,
  input wire [7:0] wr_data,
  input wire       rd_strobe,
  input wire [6:0] own_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Straps are latched on the third edge after release
  sequence s_settled; nrst [*5]; endsequence
  sequence s_stall; wr_valid && !wr_ready; endsequence
  property p_wired; sda_out == 1'b0; endproperty
  property p_fast; $rose(nrst) |-> !hs_mode; endproperty
  property p_slope; $rose(hs_mode) |-> ##[0:2] hs_slope; endproperty
  property p_force; force_high_speed_bit [*8] |-> hs_mode; endproperty
  property p_keep; $fell(hs_mode) |-> !$past(force_high_speed_bit);
  endproperty
  property p_hold;
    s_stall |=> wr_valid && $stable(wr_index) && $stable(wr_data);
  endproperty
  property p_strap; s_settled |-> $stable(own_addr); endproperty
  property p_frame; sda_oe |-> busy; endproperty
  property p_pulse; rd_strobe |=> !rd_strobe; endproperty
  a_wired: assert property (p_wired) else $error("sda high");
  a_fast: assert property (p_fast) else $error("hs at reset");
  a_slope: assert property (p_slope) else $error("slope");
  a_force: assert property (p_force) else $error("no force");
  a_keep: assert property (p_keep) else $error("hs lost");
  a_hold: assert property (p_hold) else $error("wr drop");
  a_strap: assert property (p_strap) else $error("strap");
  a_frame: assert property (p_frame) else $error("drive");
  a_pulse: assert property (p_pulse) else $error("strobe");
endmodule
bind i2cs_port i2cs_port_sva u_sva (.clock, .nrst, .sda_out, .sda_oe,
  .force_high_speed_bit, .hs_mode, .hs_slope, .busy, .wr_valid,
  .wr_ready, .wr_index, .wr_data, .rd_strobe, .own_addr);

// file: i2cs_host.sv
`timescale 1ns/10ps
// Bus master model, 160 ns link clock, idle high
module i2cs_host (
  input  wire sda_oe,
  output wire scl,
  output wire sda
);
  reg scl_r = 1'b1;
  reg sda_r = 1'b1;
  assign scl = scl_r;
  // Pull-up line: low when either party pulls it
  assign sda = sda_r & ~sda_oe;
  // Late sample leaves the slave time past its filters
  task bit_io(input b, output s);
    begin
      #20 sda_r = b;
      #80 scl_r = 1'b1;
      #50 s = sda;
      #10 scl_r = 1'b0;
    end
  endtask
  // Also used as repeated start
  task start;
    begin
      #100 sda_r = 1'b1;
      #40 scl_r = 1'b1;
      #40 sda_r = 1'b0;
      #40 scl_r = 1'b0;
    end
  endtask
  task stop;
    begin
      #40 sda_r = 1'b0;
      #40 scl_r = 1'b1;
      #40 sda_r = 1'b1;
      #40;
    end
  endtask
  // Sending 8'hff releases the line for the slave
  task byte_io(input [7:0] tx, input a, output [7:0] rx, output k);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(tx[i], rx[i]);
      bit_io(a, k);
    end
  endtask
endmodule

// file: i2cs_port_bench.sv
`timescale 1ns/10ps
// Bench: frames from the master model, register side modelled here
module i2cs_port_bench;
  reg        clock = 1'b0;
  reg        nrst = 1'b0;
  reg        mode = 1'b0;
  reg  [5:0] adr = 6'h06;
  reg        frc = 1'b0;
  reg        wr_ready = 1'b0;
  wire       scl, sda, sda_out, sda_oe, hs_mode, hs_slope, busy;
  wire       wr_valid, rd_strobe;
  wire [5:0] wr_index, rd_index;
  wire [7:0] wr_data, rd_data;
  wire [6:0] own_addr;
  reg  [7:0] regs [0:63];
  reg  [7:0] rx;
  reg        ak;
  integer    err_total = 0;
  integer    comparisons = 0;
  integer    n = 0;
  integer    i;
  always #10 clock = ~clock;
  // Accepted writes land here; reads see them at once
  always @(posedge clock) if (wr_valid && wr_ready) begin
    regs[wr_index] <= wr_data;
    n <= n + 1;
  end
  assign rd_data = regs[rd_index];
  i2cs_port dut (.clock(clock), .nrst(nrst), .two_wire_sel(1'b1),
    .address_mode_pin(mode), .adr_pin(adr), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .force_high_speed_bit(frc), .hs_mode(hs_mode),
    .hs_slope(hs_slope), .busy(busy), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data),
    .rd_index(rd_index), .rd_data(rd_data), .rd_strobe(rd_strobe),
    .own_addr(own_addr));
  i2cs_host u_host (.sda_oe(sda_oe), .scl(scl), .sda(sda));
  task chk8(input [7:0] g, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("ERROR %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task xb(input [7:0] b, input e);
    begin
      u_host.byte_io(b, 1'b1, rx, ak);
      chk8({7'h00, ak}, {7'h00, e});
    end
  endtask
  task rb(input a, input [7:0] e);
    begin
      u_host.byte_io(8'hff, a, rx, ak);
      chk8(rx, e);
    end
  endtask
  // Settle on a 5 ns offset so bus edges never meet clock edges
  task tick(input integer c);
    begin
      repeat (c) @(posedge clock);
      #5;
    end
  endtask
  task do_reset;
    begin
      @(posedge clock) nrst <= 1'b0;
      tick(5);
      @(posedge clock) nrst <= 1'b1;
      tick(12);
    end
  endtask
  task wait_n(input integer t);
    integer k;
    begin
      for (k = 0; k < 300 && n < t; k = k + 1) @(posedge clock);
      if (n < t) begin
        err_total = err_total + 1;
        report_and_stop;
      end
      tick(1);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #1500000 err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    do_reset;
    chk8({1'b0, own_addr}, 8'h2e);
    chk8({7'h00, hs_mode}, 8'h00);
    @(posedge clock) adr <= 6'h3f;
    tick(4);
    chk8({1'b0, own_addr}, 8'h2e);
    $display("strap test done");
    u_host.start;
    xb(8'h5c, 1'b0);
    xb(8'h05, 1'b0);
    xb(8'ha5, 1'b0);
    xb(8'h3c, 1'b0);
    u_host.stop;
    @(posedge clock) wr_ready <= 1'b1;
    wait_n(2);
    chk8(regs[5], 8'h3c);
    u_host.start;
    xb(8'h5e, 1'b1);
    u_host.stop;
    $display("write test done");
    u_host.start;
    xb(8'h5c, 1'b0);
    xb(8'h05, 1'b0);
    u_host.start;
    xb(8'h5d, 1'b0);
    rb(1'b0, 8'h3c);
    rb(1'b1, 8'h3c);
    u_host.stop;
    $display("read test done");
    u_host.start;
    xb(8'h09, 1'b1);
    u_host.start;
    xb(8'h5c, 1'b0);
    chk8({6'h00, hs_mode, hs_slope}, 8'h03);
    u_host.start;
    xb(8'h5c, 1'b0);
    chk8({7'h00, hs_mode}, 8'h01);
    u_host.stop;
    tick(10);
    chk8({7'h00, hs_mode}, 8'h00);
    $display("speed test done");
    @(posedge clock) wr_ready <= 1'b0;
    tick(1);
    u_host.start;
    xb(8'h5c, 1'b0);
    xb(8'h06, 1'b0);
    // Sixteen FIFO words plus the output stage hold seventeen bytes
    for (i = 0; i < 17; i = i + 1)
      xb(i[7:0], 1'b0);
    xb(8'h77, 1'b1);
    u_host.stop;
    @(posedge clock) wr_ready <= 1'b1;
    wait_n(19);
    chk8(regs[6], 8'h10);
    $display("fifo test done");
    @(posedge clock) mode <= 1'b1;
    adr <= 6'h3a;
    do_reset;
    chk8({1'b0, own_addr}, 8'h3a);
    @(posedge clock) frc <= 1'b1;
    tick(10);
    chk8({7'h00, hs_mode}, 8'h01);
    u_host.start;
    xb(8'h74, 1'b0);
    xb(8'h07, 1'b0);
    xb(8'h99, 1'b0);
    u_host.stop;
    wait_n(20);
    chk8(regs[7], 8'h99);
    $display("force test done");
    report_and_stop;
  end
endmodule
